// ==== src/stcg_defs.svh ====
/*
 * Offsets, field positions, reset values and timing figures of the sleep timer
 * and switch clock gating block.
 * Assumes a 200 MHz device clock and a 32-bit byte-addressed register bus.
 */
`ifndef STCG_DEFS_SVH
`define STCG_DEFS_SVH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define STCG_CLK_KHZ        200000

// ----------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------
`define STCG_MODE_IDX       8'h32
`define STCG_DLY_IDX        8'h36
`define STCG_GATE_IDX       8'h38
`define STCG_STAT_IDX       8'h3C
`define STCG_MODE_ADDR      8'(`STCG_MODE_IDX * 4)
`define STCG_DLY_ADDR       8'(`STCG_DLY_IDX * 4)
`define STCG_GATE_ADDR      8'(`STCG_GATE_IDX * 4)
`define STCG_STAT_ADDR      8'(`STCG_STAT_IDX * 4)

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define STCG_MODE_LSB       0
`define STCG_MODE_ENERGY    2'b01
`define STCG_DLY_LSB        0
`define STCG_RSV_BIT        4
`define STCG_AUTO_BIT       3
`define STCG_CPU_BIT        2
`define STCG_WAIT_LSB       0
`define STCG_ST_SLEEP_BIT   0
`define STCG_ST_GATED_BIT   1
`define STCG_ST_ENERGY_BIT  2
`define STCG_ST_BUSY_BIT    3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define STCG_MODE_RST       2'h0
`define STCG_DLY_RST        8'h8E
`define STCG_WAIT_RST       2'h0

// ----------------------------------------------------------------
// times and cycle counts
// ----------------------------------------------------------------
`define STCG_GS_UNIT_MS     20
`define STCG_WAIT0_MS       5300
`define STCG_WAIT1_MS       1600
`define STCG_WAIT2_MS       1
`define STCG_WAIT3_NS       3200
`define STCG_GS_UNIT_CYC    (`STCG_GS_UNIT_MS * `STCG_CLK_KHZ)
`define STCG_WAIT0_CYC      (`STCG_WAIT0_MS * `STCG_CLK_KHZ)
`define STCG_WAIT1_CYC      (`STCG_WAIT1_MS * `STCG_CLK_KHZ)
`define STCG_WAIT2_CYC      (`STCG_WAIT2_MS * `STCG_CLK_KHZ)
`define STCG_WAIT3_CYC      (`STCG_WAIT3_NS * `STCG_CLK_KHZ / 1000000)

`endif

// ==== src/stcg_pkg.sv ====
/*
 * Types shared by the sleep timer and clock gating files.
 * Assumes nothing beyond the defines header.
 */
package stcg_pkg;

    typedef struct packed {
        logic [1:0] pm_mode;
        logic [7:0] dly;
        logic       rsv4;
        logic       auto_en;
        logic       cpu_auto;
        logic [1:0] wait_sel;
    } stcg_ctrl_type;

    typedef enum logic {PS_NORMAL, PS_SLEEP} stcg_pwr_type;
    typedef enum logic {CK_RUN, CK_GATED} stcg_clk_type;

endpackage

// ==== src/stcg_timer.sv ====
/*
 * Restartable saturating up-counter with a terminal flag.
 * Assumes run and clear come from logic on the same clock.
 */
`timescale 1ns/1ps
module stcg_timer
    import stcg_pkg::*;
#(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         run,
    input  wire logic         clear,
    input  wire logic [W-1:0] limit,
    output logic              done
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (clear) begin
            cnt_d = '0;
        end else if (run && cnt_q < limit) begin
            cnt_d = cnt_q + W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // saturates at the limit; a lowered limit still ends the wait
    assign done = (cnt_q >= limit);
endmodule

// ==== src/stcg_top.sv ====
/*
 * Sleep timer and switch clock gating control, with an Avalon-MM slave.
 * Assumes line energy flags arrive from the PHYs asynchronously and MII busy
 * flags come from MAC logic on clk; an external clock gate consumes sw_clk_en.
 */
// Behaviour
// - the go-sleep count is an 8-bit read-write field in the low bits of its register, one step being 20 ms.
// - low power is entered only after no line energy has been seen without break for the go-sleep delay.
// - the go-sleep count resets to 0x8E, about 2.8 s.
// - the go-sleep delay governs only the normal-to-low-power step in energy detect mode.
// - with auto shutdown on, the switch clock stops once all three MII have been idle longer than the wait.
// - the switch clock restarts as soon as any MII becomes busy.
// - with auto shutdown off, the switch clock always runs.
// - the wait field selects 5.3 s, 1.6 s, 1 ms or 3.2 us for codes 00, 01, 10, 11.
// - power management mode 01 is energy detect mode.
`timescale 1ns/1ps
`include "stcg_defs.svh"
module stcg_top
    import stcg_pkg::*;
#(
    parameter int unsigned GS_UNIT_CYC = `STCG_GS_UNIT_CYC,
    parameter int unsigned WAIT0_CYC   = `STCG_WAIT0_CYC,
    parameter int unsigned WAIT1_CYC   = `STCG_WAIT1_CYC,
    parameter int unsigned WAIT2_CYC   = `STCG_WAIT2_CYC,
    parameter int          NPHY        = 2,
    parameter int          NMII        = 3
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic [7:0]      avs_address,
    input  wire logic            avs_read,
    input  wire logic            avs_write,
    input  wire logic [31:0]     avs_writedata,
    input  wire logic [3:0]      avs_byteenable,
    output logic      [31:0]     avs_readdata,
    output logic                 avs_waitrequest,
    input  wire logic [NPHY-1:0] line_energy,
    input  wire logic [NMII-1:0] mii_busy,
    output logic                 sw_clk_en,
    output logic                 low_power
);
    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [NPHY-1:0] en_s1_q;
    logic [NPHY-1:0] en_s2_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            en_s1_q <= '0;
            en_s2_q <= '0;
        end else begin
            en_s1_q <= line_energy;
            en_s2_q <= en_s1_q;
        end
    end

    logic energy;
    logic any_busy;
    assign energy   = |en_s2_q;
    assign any_busy = |mii_busy;

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {RG_PM, RG_DLY, RG_CT, RG_ST, RG_NONE} stcg_reg_type;

    function automatic stcg_reg_type reg_sel(input logic [7:0] a);
        case (a)
            `STCG_MODE_ADDR:   reg_sel = RG_PM;
            `STCG_DLY_ADDR:    reg_sel = RG_DLY;
            `STCG_GATE_ADDR:   reg_sel = RG_CT;
            `STCG_STAT_ADDR:   reg_sel = RG_ST;
            default:           reg_sel = RG_NONE;
        endcase
    endfunction

    stcg_ctrl_type ctrl_q;
    stcg_ctrl_type ctrl_d;
    logic          ack_q;
    logic          ack_d;
    logic [31:0]   rdata_q;
    logic [31:0]   rdata_d;
    logic [15:0]   stat;
    stcg_pwr_type  pwr_q;
    stcg_clk_type  ck_q;
    logic          wr_go;

    // one wait cycle, answer on the second edge
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign avs_readdata    = rdata_q;
    assign wr_go           = avs_write && ack_q;

    always_comb begin
        stat = '0;
        stat[`STCG_ST_SLEEP_BIT]  = (pwr_q == PS_SLEEP);
        stat[`STCG_ST_GATED_BIT]  = (ck_q == CK_GATED);
        stat[`STCG_ST_ENERGY_BIT] = energy;
        stat[`STCG_ST_BUSY_BIT]   = any_busy;
    end

    always_comb begin
        ack_d   = (avs_read || avs_write) && !ack_q;
        rdata_d = rdata_q;
        if (ack_d && avs_read) begin
            rdata_d = '0;
            case (reg_sel(avs_address))
                RG_PM:   rdata_d[1:0] = ctrl_q.pm_mode;
                RG_DLY:  rdata_d[7:0] = ctrl_q.dly;
                RG_CT:   rdata_d[4:0] = {ctrl_q.rsv4, ctrl_q.auto_en, ctrl_q.cpu_auto, ctrl_q.wait_sel};
                RG_ST:   rdata_d[15:0] = stat;
                default: rdata_d = '0;
            endcase
        end
    end

    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_go && avs_byteenable[0]) begin
            case (reg_sel(avs_address))
                RG_PM: begin
                    ctrl_d.pm_mode = avs_writedata[`STCG_MODE_LSB +: 2];
                end
                RG_DLY: begin
                    ctrl_d.dly = avs_writedata[`STCG_DLY_LSB +: 8];
                end
                RG_CT: begin
                    ctrl_d.rsv4     = avs_writedata[`STCG_RSV_BIT];
                    ctrl_d.auto_en  = avs_writedata[`STCG_AUTO_BIT];
                    ctrl_d.cpu_auto = avs_writedata[`STCG_CPU_BIT];
                    ctrl_d.wait_sel = avs_writedata[`STCG_WAIT_LSB +: 2];
                end
                default: begin
                    ctrl_d = ctrl_q;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_q           <= 1'b0;
            rdata_q         <= '0;
            ctrl_q.pm_mode  <= `STCG_MODE_RST;
            ctrl_q.dly      <= `STCG_DLY_RST;
            ctrl_q.rsv4     <= 1'b0;
            ctrl_q.auto_en  <= 1'b0;
            ctrl_q.cpu_auto <= 1'b0;
            ctrl_q.wait_sel <= `STCG_WAIT_RST;
        end else begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
            ctrl_q  <= ctrl_d;
        end
    end

    // ----------------------------------------------------------------
    // go-sleep timer
    // ----------------------------------------------------------------
    logic         ed_mode;
    logic         unit_done;
    logic         gs_clear;
    logic [7:0]   unit_cnt_q;
    logic [7:0]   unit_cnt_d;
    stcg_pwr_type pwr_d;

    assign ed_mode  = (ctrl_q.pm_mode == `STCG_MODE_ENERGY);
    assign gs_clear = energy || !ed_mode || (pwr_q == PS_SLEEP);

    stcg_timer #(.W(32)) u_gs_unit (
        .clk   (clk),
        .rst   (rst),
        .run   (!gs_clear),
        .clear (gs_clear || unit_done),
        .limit (32'(GS_UNIT_CYC - 1)),
        .done  (unit_done)
    );

    always_comb begin
        unit_cnt_d = unit_cnt_q;
        pwr_d      = pwr_q;
        if (gs_clear) begin
            unit_cnt_d = '0;
        end else if (unit_done && unit_cnt_q != 8'hFF) begin
            unit_cnt_d = unit_cnt_q + 8'h01;
        end
        case (pwr_q)
            PS_NORMAL: begin
                if (ed_mode && !energy && unit_cnt_q >= ctrl_q.dly) begin
                    pwr_d = PS_SLEEP;
                end
            end
            PS_SLEEP: begin
                if (energy || !ed_mode) begin
                    pwr_d = PS_NORMAL;
                end
            end
            default: pwr_d = PS_NORMAL;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            unit_cnt_q <= '0;
            pwr_q      <= PS_NORMAL;
        end else begin
            unit_cnt_q <= unit_cnt_d;
            pwr_q      <= pwr_d;
        end
    end

    assign low_power = (pwr_q == PS_SLEEP);

    // ----------------------------------------------------------------
    // switch clock gate
    // ----------------------------------------------------------------
    function automatic logic [31:0] wait_cycles(input logic [1:0] sel);
        case (sel)
            2'b00:   wait_cycles = 32'(WAIT0_CYC);
            2'b01:   wait_cycles = 32'(WAIT1_CYC);
            2'b10:   wait_cycles = 32'(WAIT2_CYC);
            default: wait_cycles = 32'(`STCG_WAIT3_CYC);
        endcase
    endfunction

    logic         idle_done;
    logic         idle_clear;
    logic [31:0]  idle_limit;
    stcg_clk_type ck_d;

    assign idle_limit = wait_cycles(ctrl_q.wait_sel);
    assign idle_clear = any_busy || !ctrl_q.auto_en || (ck_q == CK_GATED);

    stcg_timer #(.W(32)) u_idle (
        .clk   (clk),
        .rst   (rst),
        .run   (!idle_clear),
        .clear (idle_clear),
        .limit (idle_limit),
        .done  (idle_done)
    );

    always_comb begin
        ck_d = ck_q;
        case (ck_q)
            CK_RUN: begin
                if (ctrl_q.auto_en && !any_busy && idle_done) begin
                    ck_d = CK_GATED;
                end
            end
            CK_GATED: begin
                if (any_busy || !ctrl_q.auto_en) begin
                    ck_d = CK_RUN;
                end
            end
            default: ck_d = CK_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ck_q <= CK_RUN;
        end else begin
            ck_q <= ck_d;
        end
    end

    // restart is combinational so the first busy cycle already has a clock
    assign sw_clk_en = (ck_q == CK_RUN) || any_busy || !ctrl_q.auto_en;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_dly_write;
        @(posedge clk) disable iff (rst)
        (wr_go && avs_byteenable[0] && avs_address == `STCG_DLY_ADDR) |=> ctrl_q.dly == $past(avs_writedata[7:0]);
    endproperty
    a_dly_write: assert property (p_dly_write) else $error("go-sleep count not written");

    property p_sleep_entry;
        @(posedge clk) disable iff (rst)
        $rose(low_power) |-> $past(unit_cnt_q) >= $past(ctrl_q.dly) && !$past(energy);
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entered before delay");

    property p_dly_reset;
        @(posedge clk)
        $past(rst) |-> ctrl_q.dly == `STCG_DLY_RST && !low_power;
    endproperty
    a_dly_reset: assert property (p_dly_reset) else $error("go-sleep reset value wrong");

    property p_sleep_mode;
        @(posedge clk) disable iff (rst)
        $rose(low_power) |-> $past(ctrl_q.pm_mode) == 2'b01;
    endproperty
    a_sleep_mode: assert property (p_sleep_mode) else $error("sleep outside energy detect mode");

    property p_gate_cause;
        @(posedge clk) disable iff (rst)
        $fell(sw_clk_en) |-> $past(ctrl_q.auto_en) && $past(idle_done) && !$past(any_busy);
    endproperty
    a_gate_cause: assert property (p_gate_cause) else $error("clock gated without idle wait");

    property p_wake;
        @(posedge clk) disable iff (rst)
        (ck_q == CK_GATED && any_busy) |-> sw_clk_en ##1 (ck_q == CK_RUN);
    endproperty
    a_wake: assert property (p_wake) else $error("clock not restored on busy");

    property p_always_on;
        @(posedge clk) disable iff (rst)
        !ctrl_q.auto_en [*2] |-> sw_clk_en && ck_q == CK_RUN;
    endproperty
    a_always_on: assert property (p_always_on) else $error("clock stopped while disabled");

    property p_short_wait;
        @(posedge clk) disable iff (rst)
        (ctrl_q.auto_en && !any_busy && ck_q == CK_RUN && ctrl_q.wait_sel == 2'b11) [*2] |-> idle_limit == 32'd640;
    endproperty
    a_short_wait: assert property (p_short_wait) else $error("wait select 11 not 3.2 us");

    property p_mode_exit;
        @(posedge clk) disable iff (rst)
        (low_power && ctrl_q.pm_mode != 2'b01) |=> !low_power;
    endproperty
    a_mode_exit: assert property (p_mode_exit) else $error("sleep held outside mode 01");

    property p_restart;
        @(posedge clk) disable iff (rst)
        energy |=> unit_cnt_q == 8'h00;
    endproperty
    a_restart: assert property (p_restart) else $error("no-energy count not restarted");
endmodule

// ==== tb/stcg_far_model.sv ====
/*
 * Far-side model: per-port MII traffic and per-PHY line energy.
 * Assumes the bench commands activity on clk; outputs change only after an edge.
 */
`timescale 1ns/1ps
module stcg_far_model
    import stcg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [2:0] busy_set,
    input  wire logic [1:0] energy_set,
    output logic      [2:0] mii_busy,
    output logic      [1:0] line_energy
);
    // ----------------------------------------------------------------
    // registered traffic and energy, like a MAC and PHY would present them
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            mii_busy    <= 3'h0;
            line_energy <= 2'h3;
        end else begin
            mii_busy    <= busy_set;
            line_energy <= energy_set;
        end
    end
endmodule

// ==== tb/tb_stcg_top.sv ====
/*
 * Self-checking bench for the sleep timer and switch clock gating block.
 * Assumes the shortened count parameters below; all timing expectations but the 640-cycle wait of code 11 derive from them.
 */
`timescale 1ns/1ps
`include "stcg_defs.svh"
module tb_stcg_top
    import stcg_pkg::*;
;
    localparam int GSU = 10;
    localparam int LIM [4] = '{40, 30, 20, 640};

    logic        clk;
    logic        rst;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  line_energy;
    logic [2:0]  mii_busy;
    logic [2:0]  busy_set;
    logic [1:0]  energy_set;
    logic        sw_clk_en;
    logic        low_power;
    logic [31:0] rd;
    int          num_errors;
    int          comparisons;
    int          cycles;

    stcg_top #(.GS_UNIT_CYC(GSU), .WAIT0_CYC(40), .WAIT1_CYC(30), .WAIT2_CYC(20)) uut (
        .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .line_energy(line_energy), .mii_busy(mii_busy), .sw_clk_en(sw_clk_en), .low_power(low_power));

    stcg_far_model far (
        .clk(clk), .rst(rst), .busy_set(busy_set), .energy_set(energy_set),
        .mii_busy(mii_busy), .line_energy(line_energy));

    // ----------------------------------------------------------------
    // clock and hang guard
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic report_and_stop();
        $display("comparisons=%0d mismatches=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        num_errors = 0;
        comparisons = 0;
        cycles = 0;
        rst = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        busy_set = 3'h7;
        energy_set = 2'h3;
        repeat (16) @(posedge clk);
        rst <= 1'b0;

        // reset values, field widths, refusals
        bus_read(`STCG_DLY_ADDR, rd);
        check(rd, 32'h0000008E);
        bus_read(`STCG_MODE_ADDR, rd);
        check(rd, 32'h00000000);
        bus_read(`STCG_GATE_ADDR, rd);
        check(rd, 32'h00000000);
        bus_write(`STCG_DLY_ADDR, 32'hFFFF_FFA5, 4'hF);
        bus_read(`STCG_DLY_ADDR, rd);
        check(rd, 32'h000000A5);
        bus_write(`STCG_DLY_ADDR, 32'h0000_0011, 4'hE);
        bus_read(`STCG_DLY_ADDR, rd);
        check(rd, 32'h000000A5);
        bus_write(8'h04, 32'h0000_FFFF, 4'hF);
        bus_read(8'h04, rd);
        check(rd, 32'h00000000);
        bus_write(`STCG_GATE_ADDR, 32'h0000_FFF7, 4'hF);
        bus_read(`STCG_GATE_ADDR, rd);
        check(rd, 32'h00000017);
        $display("test registers done");

        // auto shutdown off keeps the clock running
        busy_set <= 3'h0;
        settle(800);
        check({31'h0, sw_clk_en}, 32'h1);
        $display("test auto off done");

        // gating after each wait code, wake on busy
        for (int c = 0; c < 4; c++) begin
            busy_set <= 3'h1 << (c % 3);
            bus_write(`STCG_GATE_ADDR, 32'h8 | c, 4'hF);
            busy_set <= 3'h0;
            settle(LIM[c] + 1);
            check({31'h0, sw_clk_en}, 32'h1);
            settle(1);
            check({31'h0, sw_clk_en}, 32'h0);
            busy_set <= 3'h4 >> (c % 3);
            settle(1);
            check({31'h0, sw_clk_en}, 32'h1);
        end
        bus_write(`STCG_GATE_ADDR, 32'hA, 4'hF);
        busy_set <= 3'h0;
        settle(15);
        busy_set <= 3'h2;
        @(posedge clk);
        busy_set <= 3'h0;
        settle(15);
        check({31'h0, sw_clk_en}, 32'h1);
        settle(10);
        check({31'h0, sw_clk_en}, 32'h0);
        $display("test clock gating done");

        // go-sleep delay only in energy detect mode
        busy_set <= 3'h7;
        bus_write(`STCG_GATE_ADDR, 32'h0, 4'hF);
        busy_set <= 3'h0;
        bus_write(`STCG_DLY_ADDR, 32'h3, 4'hF);
        energy_set <= 2'h0;
        settle(100);
        check({31'h0, low_power}, 32'h0);
        bus_write(`STCG_MODE_ADDR, {30'h0, `STCG_MODE_ENERGY}, 4'hF);
        bus_read(`STCG_MODE_ADDR, rd);
        check(rd, 32'h00000001);
        settle(27);
        check({31'h0, low_power}, 32'h0);
        settle(1);
        check({31'h0, low_power}, 32'h1);
        bus_read(`STCG_STAT_ADDR, rd);
        check(rd & 32'h5, 32'h1);
        energy_set <= 2'h2;
        settle(6);
        check({31'h0, low_power}, 32'h0);
        energy_set <= 2'h0;
        settle(20);
        energy_set <= 2'h1;
        settle(4);
        energy_set <= 2'h0;
        settle(22);
        check({31'h0, low_power}, 32'h0);
        settle(20);
        check({31'h0, low_power}, 32'h1);
        bus_write(`STCG_MODE_ADDR, 32'h0, 4'hF);
        settle(4);
        check({31'h0, low_power}, 32'h0);
        $display("test go sleep done");

        report_and_stop();
    end
endmodule
